// File: hw/srs_defines.svh
// constants of the speed reference selector: offsets, codes, timings
// assumes 0.01 Hz reference units and a 20 MHz system clock
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define SRS_CLK_HZ 20000000
`define SRS_BLINK_HALF_MS 250
`define SRS_BLINK_HALF_CYCLES ((`SRS_CLK_HZ / 1000) * `SRS_BLINK_HALF_MS)

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define SRS_NUM_INPUTS 6
`define SRS_NUM_PRESETS 16

// ----------------------------------------------------------------
// input terminal function codes
// ----------------------------------------------------------------
`define SRS_FN_NONE 8'h00
`define SRS_FN_STEP1 8'h03
`define SRS_FN_STEP2 8'h04
`define SRS_FN_STEP3 8'h05
`define SRS_FN_STEP4 8'h06
`define SRS_FN_JOGSEL 8'h07
`define SRS_FN_FWD_JOG 8'h0C
`define SRS_FN_REV_JOG 8'h0D

// ----------------------------------------------------------------
// reference source and second analog function codes
// ----------------------------------------------------------------
`define SRS_SRC_KEYPAD 1'b0
`define SRS_SRC_ANALOG 1'b1
`define SRS_AUX_FREQ 8'h02

// ----------------------------------------------------------------
// frequency limits and reset values (0.01 Hz units)
// ----------------------------------------------------------------
`define SRS_FREQ_MAX 16'h9C40
`define SRS_JOG_RST 16'h0258
`define SRS_UNIT_HZ 2'h0

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SRS_OFS_TERM_LO 8'h00
`define SRS_OFS_TERM_HI 8'h04
`define SRS_OFS_CONFIG 8'h08
`define SRS_OFS_JOG 8'h0C
`define SRS_OFS_STATUS 8'h10
`define SRS_PRESET_PAGE 2'h1

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SRS_CFG_SRC 0
`define SRS_CFG_AUX 15:8
`define SRS_CFG_UNIT 17:16
`define SRS_ST_DIR 16
`define SRS_ST_RUN 17
`define SRS_ST_IND 18
`define SRS_ST_STATE 21:20

`endif

// File: hw/srs_pkg.sv
// types shared by the speed reference selector files
// assumes nothing beyond a SystemVerilog compiler
package srs_pkg;
    typedef logic [15:0] srs_freq_t;  // frequency, 0.01 Hz units
    typedef logic [7:0] srs_func_t;   // terminal function code
    typedef logic [1:0] srs_unit_t;   // display unit code
    typedef enum logic [1:0] {
        SRS_IDLE,
        SRS_RUN,
        SRS_STOPPING
    } srs_state_e;
endpackage

// File: hw/srs_sync.sv
// two flip-flop synchroniser for a bus of pin levels
// assumes each bit is a slow level; wide words may tear for one cycle
`timescale 1ns/10ps
module srs_sync #(
    parameter int unsigned W = 1
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;  // first stage, read only by q

    // ----------------------------------------------------------------
    // two stages, cleared on reset
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// File: hw/srs_tick.sv
// free-running divider giving a one-cycle enable every n cycles
// assumes n of at least two
`timescale 1ns/10ps
module srs_tick #(
    parameter int unsigned N = 2
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    output logic tick
);
    localparam int unsigned W = (N > 2) ? $clog2(N) : 1;
    logic [W-1:0] cnt;       // cycles since last tick
    logic [W-1:0] next_cnt;
    logic next_tick;

    // ----------------------------------------------------------------
    // count and wrap
    // ----------------------------------------------------------------
    always_comb begin
        next_tick = (cnt == W'(N - 1));
        next_cnt = next_tick ? '0 : cnt + W'(1);
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

// File: hw/srs_top.sv
// speed reference selector: jog and multi-step preset selection
// assumes an apb master on CLOCK, switch contacts on CONTACT_IN pins
// and a motor core that reports MOTOR_STOPPED on the same clock
// Operation
// - forward jog input runs forward at jog frequency
// - reverse jog input runs reverse at jog frequency
// - jog runs without any run command
// - either jog function on any terminal
// - one jog setting, 0 to 400 Hz, 6 Hz default
// - jog reference overrides all preset steps
// - preset units follow display unit setting
// - step bit 1 alone selects preset 2
// - step bit 2 alone selects preset 3
// - both step bits select preset 4
// - up to 17 references, five inputs
// - step 1 local or keypad uses preset 1
// - step 1 remote analog uses first analog
// - step 2 with aux function uses second analog
// - jog input opening stops the motor unless the run command is on
// - run indicator flashes until motor stops
`include "srs_defines.svh"
`timescale 1ns/10ps
module srs_top #(
    parameter int unsigned BLINK_HALF_CYCLES = `SRS_BLINK_HALF_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [5:0] CONTACT_IN,
    input wire logic LOCAL_REMOTE_SELECT,
    input wire logic RUN_CMD,
    input wire logic RUN_REVERSE,
    input wire srs_pkg::srs_freq_t FIRST_ANALOG_INPUT,
    input wire srs_pkg::srs_freq_t SECOND_ANALOG_INPUT,
    input wire logic MOTOR_STOPPED,
    output srs_pkg::srs_freq_t FREQ_REF,
    output logic DIR_REVERSE,
    output logic RUN_ENABLE,
    output logic RUN_INDICATOR,
    output srs_pkg::srs_unit_t REF_UNIT
);
    import srs_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    logic [5:0] contact;  // synced contact levels
    logic local_mode;     // synced local/remote select, 1 = local
    logic run_s;          // synced run command
    logic rev_s;          // synced run direction
    srs_freq_t a1;        // synced first analog input
    srs_freq_t a2;        // synced second analog input
    logic blink_tick;     // half-period of the flashing indicator

    srs_sync #(.W(41)) u_sync (
        .CLOCK(CLOCK),
        .RST_B(RST_B),
        .d({CONTACT_IN, LOCAL_REMOTE_SELECT, RUN_CMD, RUN_REVERSE,
            FIRST_ANALOG_INPUT, SECOND_ANALOG_INPUT}),
        .q({contact, local_mode, run_s, rev_s, a1, a2})
    );

    srs_tick #(.N(BLINK_HALF_CYCLES)) u_blink (
        .CLOCK(CLOCK),
        .RST_B(RST_B),
        .tick(blink_tick)
    );

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // any terminal given this function is closed
    function automatic logic any_func(input logic [5:0][7:0] fs,
                                      input logic [5:0] in,
                                      input srs_func_t code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `SRS_NUM_INPUTS; i++) begin
            hit = hit | (in[i] & (fs[i] == code));
        end
        return hit;
    endfunction

    // address falls in the preset page on a word boundary
    function automatic logic is_preset(input logic [7:0] a);
        return (a[7:6] == `SRS_PRESET_PAGE) && (a[1:0] == 2'h0);
    endfunction

    // limit a written frequency to the top of the range
    function automatic srs_freq_t clamp(input srs_freq_t f);
        return (f > `SRS_FREQ_MAX) ? `SRS_FREQ_MAX : f;
    endfunction

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [5:0][7:0] term_func;   // function code per terminal
    logic src_sel;                // reference source in remote mode
    srs_func_t aux_func;          // second analog function code
    srs_unit_t unit_sel;          // display unit code
    srs_freq_t jog_freq;          // jog frequency setting
    srs_freq_t preset [16];       // preset frequencies 1..16
    logic [5:0][7:0] next_term_func;
    logic next_src_sel;
    srs_func_t next_aux_func;
    srs_unit_t next_unit_sel;
    srs_freq_t next_jog_freq;
    srs_freq_t next_preset [16];
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    srs_state_e state;            // run sequencing state
    logic [31:0] rd_word;         // read mux output
    logic mapped;                 // address decodes to a register
    logic setup;                  // apb setup cycle
    logic wr_go;                  // write completes this edge

    // decode, read mux and register updates
    always_comb begin
        setup = PSEL & ~PENABLE;
        wr_go = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
        mapped = is_preset(PADDR);
        rd_word = 32'h0000_0000;
        case (PADDR)
            `SRS_OFS_TERM_LO: begin
                rd_word = term_func[3:0];
                mapped = 1'b1;
            end
            `SRS_OFS_TERM_HI: begin
                rd_word = {16'h0000, term_func[5:4]};
                mapped = 1'b1;
            end
            `SRS_OFS_CONFIG: begin
                rd_word[`SRS_CFG_SRC] = src_sel;
                rd_word[`SRS_CFG_AUX] = aux_func;
                rd_word[`SRS_CFG_UNIT] = unit_sel;
                mapped = 1'b1;
            end
            `SRS_OFS_JOG: begin
                rd_word[15:0] = jog_freq;
                mapped = 1'b1;
            end
            `SRS_OFS_STATUS: begin
                // live selection, readable while the drive runs
                rd_word[15:0] = FREQ_REF;
                rd_word[`SRS_ST_DIR] = DIR_REVERSE;
                rd_word[`SRS_ST_RUN] = RUN_ENABLE;
                rd_word[`SRS_ST_IND] = RUN_INDICATOR;
                rd_word[`SRS_ST_STATE] = state;
                mapped = 1'b1;
            end
            default: begin
                if (is_preset(PADDR)) begin
                    rd_word[15:0] = preset[PADDR[5:2]];
                end
            end
        endcase
        // zero-wait slave: pready rises in every access phase
        next_pready = setup;
        next_prdata = (setup & ~PWRITE & mapped) ? rd_word : 32'h0;
        next_pslverr = setup & ~mapped;
        next_term_func = term_func;
        next_src_sel = src_sel;
        next_aux_func = aux_func;
        next_unit_sel = unit_sel;
        next_jog_freq = jog_freq;
        next_preset = preset;
        if (wr_go) begin
            case (PADDR)
                // any function may go on any terminal
                `SRS_OFS_TERM_LO: next_term_func[3:0] = PWDATA;
                `SRS_OFS_TERM_HI: next_term_func[5:4] = PWDATA[15:0];
                `SRS_OFS_CONFIG: begin
                    next_src_sel = PWDATA[`SRS_CFG_SRC];
                    next_aux_func = PWDATA[`SRS_CFG_AUX];
                    next_unit_sel = PWDATA[`SRS_CFG_UNIT];
                end
                // one jog value, held inside its range
                `SRS_OFS_JOG: next_jog_freq = clamp(PWDATA[15:0]);
                default: begin
                    if (is_preset(PADDR)) begin
                        next_preset[PADDR[5:2]] = clamp(PWDATA[15:0]);
                    end
                end
            endcase
        end
    end

    // register file flops
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            term_func <= '0;
            src_sel <= `SRS_SRC_KEYPAD;
            aux_func <= `SRS_FN_NONE;
            unit_sel <= `SRS_UNIT_HZ;
            jog_freq <= `SRS_JOG_RST;
            preset <= '{default: '0};
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            term_func <= next_term_func;
            src_sel <= next_src_sel;
            aux_func <= next_aux_func;
            unit_sel <= next_unit_sel;
            jog_freq <= next_jog_freq;
            preset <= next_preset;
            PRDATA <= next_prdata;
            PREADY <= next_pready;
            PSLVERR <= next_pslverr;
        end
    end

    // ----------------------------------------------------------------
    // reference selection and run sequencing
    // ----------------------------------------------------------------
    logic fj;            // forward jog terminal closed
    logic rj;            // reverse jog terminal closed
    logic jsel;          // jog reference selected
    logic [3:0] step;    // step bits, 0 means speed step 1
    logic demand;        // motion wanted this cycle
    srs_state_e next_state;
    srs_freq_t next_freq;
    logic next_dir;
    logic next_run;
    logic next_ind;

    always_comb begin
        fj = any_func(term_func, contact, `SRS_FN_FWD_JOG);
        rj = any_func(term_func, contact, `SRS_FN_REV_JOG);
        jsel = any_func(term_func, contact, `SRS_FN_JOGSEL);
        // four step bits plus jog give 17 references
        step = {any_func(term_func, contact, `SRS_FN_STEP4),
                any_func(term_func, contact, `SRS_FN_STEP3),
                any_func(term_func, contact, `SRS_FN_STEP2),
                any_func(term_func, contact, `SRS_FN_STEP1)};
        next_freq = FREQ_REF;
        next_dir = DIR_REVERSE;
        if (fj & rj) begin
            demand = 1'b0;  // conflicting jogs ask for a stop
        end else if (fj | rj) begin
            // jog needs no run command
            demand = 1'b1;
            next_freq = jog_freq;
            next_dir = rj;
        end else begin
            demand = run_s;  // jog released: only run holds motion
            next_dir = rev_s;
            if (jsel) begin
                next_freq = jog_freq;
            end else if (step == 4'h0) begin
                if (local_mode | (src_sel == `SRS_SRC_KEYPAD)) begin
                    next_freq = preset[0];
                end else begin
                    next_freq = a1;
                end
            end else if (step == 4'h1 && aux_func == `SRS_AUX_FREQ) begin
                next_freq = a2;
            end else begin
                next_freq = preset[step];
            end
        end
        case (state)
            SRS_IDLE: next_state = demand ? SRS_RUN : SRS_IDLE;
            SRS_RUN: next_state = demand ? SRS_RUN : SRS_STOPPING;
            SRS_STOPPING: begin
                if (demand) begin
                    next_state = SRS_RUN;
                end else if (MOTOR_STOPPED) begin
                    next_state = SRS_IDLE;
                end else begin
                    next_state = SRS_STOPPING;
                end
            end
            default: next_state = SRS_IDLE;
        endcase
        next_run = (next_state == SRS_RUN);
        // steady while running, flashing while coasting down
        case (next_state)
            SRS_RUN: next_ind = 1'b1;
            SRS_STOPPING: begin
                next_ind = (state != SRS_STOPPING) ? 1'b0 :
                           (blink_tick ? ~RUN_INDICATOR : RUN_INDICATOR);
            end
            default: next_ind = 1'b0;
        endcase
    end

    // reference and run flops
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state <= SRS_IDLE;
            FREQ_REF <= '0;
            DIR_REVERSE <= 1'b0;
            RUN_ENABLE <= 1'b0;
            RUN_INDICATOR <= 1'b0;
            REF_UNIT <= `SRS_UNIT_HZ;
        end else begin
            state <= next_state;
            FREQ_REF <= next_freq;
            DIR_REVERSE <= next_dir;
            RUN_ENABLE <= next_run;
            RUN_INDICATOR <= next_ind;
            REF_UNIT <= unit_sel;  // core reads presets in this unit
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);

    logic plain;  // no jog activity at all
    assign plain = !fj && !rj && !jsel;

    a_fwd_jog: assert property (fj && !rj |=> RUN_ENABLE &&
        !DIR_REVERSE && FREQ_REF == $past(jog_freq))
        else $error("forward jog not applied");
    a_rev_jog: assert property (rj && !fj && !run_s |=> RUN_ENABLE &&
        DIR_REVERSE && FREQ_REF == $past(jog_freq))
        else $error("reverse jog not applied");
    a_jog_range: assert property (jog_freq <= `SRS_FREQ_MAX)
        else $error("jog setting out of range");
    a_jog_prio: assert property (jsel && !fj && !rj |=>
        FREQ_REF == $past(jog_freq))
        else $error("jog reference lost priority");
    a_step_two: assert property (plain && step == 4'h1 &&
        aux_func != `SRS_AUX_FREQ |=> FREQ_REF == $past(preset[1]))
        else $error("step 2 preset not used");
    a_step_three: assert property (plain && step == 4'h2 |=>
        FREQ_REF == $past(preset[2]))
        else $error("step 3 preset not used");
    a_step_four: assert property (plain && step == 4'h3 |=>
        FREQ_REF == $past(preset[3]))
        else $error("step 4 preset not used");
    a_step_one: assert property (plain && step == 4'h0 &&
        (local_mode || src_sel == `SRS_SRC_KEYPAD) |=>
        FREQ_REF == $past(preset[0]))
        else $error("step 1 preset not used");
    a_analog_one: assert property (plain && step == 4'h0 &&
        !local_mode && src_sel == `SRS_SRC_ANALOG |=> FREQ_REF == $past(a1))
        else $error("first analog not used");
    a_analog_aux: assert property (plain && step == 4'h1 &&
        aux_func == `SRS_AUX_FREQ |=> FREQ_REF == $past(a2))
        else $error("second analog not used");
    a_jog_open: assert property ($fell(fj) && !rj && !run_s |=>
        !RUN_ENABLE ##1 !RUN_ENABLE)
        else $error("motor kept running after jog opened");
    a_blink_flash: assert property (state == SRS_STOPPING &&
        next_state == SRS_STOPPING && blink_tick |=>
        RUN_INDICATOR != $past(RUN_INDICATOR))
        else $error("run indicator not flashing");
    a_jog_clash: assert property (fj && rj |=> !RUN_ENABLE)
        else $error("conflicting jogs produced motion");

    c_jog_run: cover property (fj && !rj ##1 RUN_ENABLE);
    c_stop_done: cover property (state == SRS_STOPPING ##1
        state == SRS_IDLE);
    c_step_four: cover property (plain && step == 4'h3 && run_s);
    c_analog_aux: cover property (plain && step == 4'h1 &&
        aux_func == `SRS_AUX_FREQ);
endmodule

// File: verification/srs_switch_bank.sv
// model of the external switches wired to the contact terminals
// assumes a pull-down on every terminal: an open switch reads low
`timescale 1ns/10ps
module srs_switch_bank (
    input wire logic CLOCK,
    input wire logic [5:0] sw_close,
    output logic [5:0] CONTACT_IN
);
    // ----------------------------------------------------------------
    // contacts
    // ----------------------------------------------------------------
    // a closed switch drives its terminal high; changes land just after
    // an edge, like a real slow contact seen by the synchroniser
    initial CONTACT_IN = 6'h00;
    always @(posedge CLOCK) begin
        CONTACT_IN <= sw_close;
    end
endmodule

// File: verification/srs_top_tb_top.sv
// self-checking bench for the speed reference selector
// assumes apb answers on the design's own pace; status read back
`timescale 1ns/10ps
module srs_top_tb_top;
    import srs_pkg::*;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, local_sel = 1, run_cmd = 0, motor_stop = 0;
    logic run_rev = 0, prev_ind; // run direction pin, last indicator level
    logic [5:0] sw = 6'h00, contact;
    srs_freq_t a1 = 16'h0, a2 = 16'h0, freq_ref, pre[4], jog;
    logic dir_rev, run_en, run_ind;
    srs_unit_t ref_unit;
    logic [64:0] notes[$]; // {error, mask, expected}
    logic [64:0] nt;
    int err_count = 0, n_tests = 0, seed = 32'hff0a, flips;
    always #25 clk = ~clk; // 20 MHz
    srs_switch_bank sws (.CLOCK(clk), .sw_close(sw), .CONTACT_IN(contact));
    srs_top #(.BLINK_HALF_CYCLES(8)) dut (.CLOCK(clk), .RST_B(rst_b),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CONTACT_IN(contact),
        .LOCAL_REMOTE_SELECT(local_sel), .RUN_CMD(run_cmd),
        .RUN_REVERSE(run_rev), .FIRST_ANALOG_INPUT(a1),
        .SECOND_ANALOG_INPUT(a2), .MOTOR_STOPPED(motor_stop),
        .FREQ_REF(freq_ref), .DIR_REVERSE(dir_rev), .RUN_ENABLE(run_en),
        .RUN_INDICATOR(run_ind), .REF_UNIT(ref_unit));
    // ----------------------------------------------------------------
    // checking helpers
    // ----------------------------------------------------------------
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(input string what, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (e !== s) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", what, e, s);
        end
    endtask
    // apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // pready is judged at the rising edge only, request still held
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
            input logic er = 0);
        notes.push_back({er, m, e});
        apb(0, a, 32'h0);
    endtask
    // status read, masked to the fields that are settled
    task st(input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
        repeat (6) @(posedge clk); // switch edge, 2 sync edges plus output edge, with margin
        // the output pins must agree with the status word
        chk("ref pins", e & m & 32'h0003FFFF,
            {14'h0, run_en, dir_rev, freq_ref} & m & 32'h0003FFFF);
        rd(8'h10, e, m);
    endtask
    // monitor: every read answer takes the oldest note
    // read data is taken at the same rising edge that sees pready high
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (notes.size() == 0) begin
                chk("unexpected read", 32'h0, 32'h1);
            end else begin
                nt = notes.pop_front();
                chk("rdata", nt[31:0] & nt[63:32], prdata & nt[63:32]);
                chk("slverr", {31'h0, nt[64]}, {31'h0, pslverr});
            end
        end
    end
    // watchdog, well beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop;
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1;
        rd(8'h0C, 32'h00000258, 32'hFFFF);
        rd(8'h40, 32'h0, 32'hFFFFFFFF);
        rd(8'h30, 32'h0, 32'hFFFFFFFF, 1);
        apb(1, 8'h0C, 32'h0000FFFF);
        rd(8'h0C, 32'h00009C40, 32'hFFFF);
        jog = 16'($unsigned($random(seed)) % 40001);
        apb(1, 8'h0C, {16'h0, jog});
        for (int i = 0; i < 4; i++) begin
            pre[i] = 16'($unsigned($random(seed)) % 40001);
            apb(1, 8'h40 + 8'(4 * i), {16'h0, pre[i]});
        end
        a1 <= 16'($unsigned($random(seed)) % 40001);
        a2 <= 16'($unsigned($random(seed)) % 40001);
        // t1 fwd jog, t2 rev jog, t3 jog select, t5/t6 step bits
        apb(1, 8'h00, 32'h00070D0C);
        apb(1, 8'h04, 32'h00000403);
        run_cmd <= 1;
        for (int s = 0; s < 4; s++) begin
            sw <= 6'(s << 4);
            st(32'h00160000 | pre[s]);
        end
        local_sel <= 0;
        apb(1, 8'h08, 32'h00000201);
        sw <= 6'h00;
        st(32'h00160000 | a1);
        sw <= 6'h10;
        st(32'h00160000 | a2);
        run_rev <= 1;
        sw <= 6'h34;
        st(32'h00170000 | jog);
        // step bits 3 and 4 on t5/t6 reach preset 13
        apb(1, 8'h04, 32'h00000605);
        pre[3] = 16'($unsigned($random(seed)) % 40001);
        apb(1, 8'h70, {16'h0, pre[3]});
        sw <= 6'h30;
        st(32'h00170000 | pre[3]);
        apb(1, 8'h04, 32'h00000403);
        run_cmd <= 0;
        run_rev <= 0;
        sw <= 6'h00;
        st(32'h00200000, 32'h00320000);
        motor_stop <= 1;
        st(32'h0, 32'hFFFF0000);
        motor_stop <= 0;
        sw <= 6'h01;
        st(32'h00160000 | jog);
        sw <= 6'h00;
        st(32'h00200000, 32'h00320000);
        flips = 0;
        prev_ind = run_ind;
        repeat (24) begin
            @(posedge clk);
            flips += int'(run_ind !== prev_ind);
            prev_ind = run_ind;
        end
        chk("indicator flashing", 32'h1, {31'h0, flips > 0});
        sw <= 6'h02;
        st(32'h00170000 | jog);
        sw <= 6'h03;
        st(32'h00200000, 32'h00320000);
        apb(1, 8'h08, 32'h00020000);
        repeat (3) @(posedge clk);
        chk("ref unit", 32'h2, {30'h0, ref_unit});
        report_and_stop;
    end
endmodule
